/* File: inc/pcc_pkg.sv */
`default_nettype none
package pcc_pkg;
  localparam logic [7:0] CMD_OFFSET = 8'h04;
  localparam int BIT_IO = 0;
  localparam int BIT_MEM = 1;
  localparam int BIT_MASTER = 2;
  localparam int BIT_SPECIAL = 3;
  localparam int BIT_MWI = 4;
  localparam int BIT_SNOOP = 5;
  localparam int BIT_PARITY = 6;
  localparam int BIT_STEP = 7;
  localparam int BIT_SERR = 8;
  localparam int BIT_FBB = 9;
  localparam int BIT_DPE = 15;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // Writable bits of the command register
  localparam logic [15:0] CMD_WMASK = 16'h0357;
  // Fixed values of the non-writable bits
  localparam logic [15:0] CMD_FIXED = 16'h0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
    logic [1:0] byteEn;
    logic [15:0] data;
  } pcc_cfg_s;

  typedef struct packed {
    logic memSpaceHit;
    logic ioSpaceHit;
    logic specialCycle;
    logic paletteWrite;
    logic masterReq;
    logic masterWantsMwi;
    logic dataParityErr;
    logic addrParityErr;
  } pcc_evt_s;
endpackage
`default_nettype wire

/* File: rtl/pcc_command_low.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Stepping bit is fixed; this function never steps, so it reads zero.
// - A function able to both step and not would make it writable, reset one.
// - Parity response one: data parity errors drive the error pin.
// - Parity response zero: error flag still set, no error pin, continue.
// - Parity response bit is implemented and cleared by reset.
// - Outgoing parity is always generated, regardless of checking.
// - Snoop bit zero: palette writes are claimed like any other access.
// - Snoop bit one: palette writes are not claimed but snooped; here the bit is fixed at zero.
// - Write-invalidate bit zero: master uses plain memory write.
// - Write-invalidate bit one: master may use write and invalidate.
// - Special cycle bit zero: every special cycle is ignored.
// - Special cycle bit one: special cycles may be monitored; here the bit is fixed at zero.
// - Master bit zero: no own bus transaction is started.
// - Master bit one: the bus may be requested as initiator.
// - Memory accesses answered only while memory enable is one.
// - I/O accesses answered only while I/O enable is one.
// - Command register at 04h; all zeros leaves only configuration access.
// - Address parity errors reach system error only if both enables set.
module pcc_command_low
  import pcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire pcc_cfg_s cfgReq,
  input wire logic [31:0] txData,
  input wire logic [3:0] txByteEnN,
  input wire logic clearDpe,
  input wire pcc_evt_s evt,
  output logic [15:0] cfgRdata,
  output logic cfgRvalid,
  output logic memClaim,
  output logic ioClaim,
  output logic paletteSnoop,
  output logic specialAccept,
  output logic masterGrantOk,
  output logic useMwi,
  output logic parityOut,
  output logic parityErrN,
  output logic systemErrN,
  output logic detectedParityErr
);
  logic rstMeta, rstSync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  logic [15:0] cmd_q, cmd_d, rd_q, rd_d;
  logic rv_q, rv_d, dpe_q, dpe_d, perrN_q, perrN_d, serrN_q, serrN_d;
  logic mem_q, mem_d, io_q, io_d, snp_q, snp_d, sc_q, sc_d;
  logic bm_q, bm_d, mwi_q, mwi_d, par_q, par_d;
  logic hit;
  logic [15:0] wmask;

  always_comb begin
    hit = cfgReq.valid && (cfgReq.offset == CMD_OFFSET);
    wmask = CMD_WMASK & {{8{cfgReq.byteEn[1]}}, {8{cfgReq.byteEn[0]}}};
    cmd_d = cmd_q;
    if (hit && cfgReq.write) begin
      cmd_d = (cmd_q & ~wmask) | (cfgReq.data & wmask);
    end
    cmd_d = (cmd_d & CMD_WMASK) | CMD_FIXED;
    rv_d = hit && !cfgReq.write;
    rd_d = rv_d ? ((cmd_q & CMD_WMASK) | CMD_FIXED) : 16'h0000;
    dpe_d = dpe_q;
    if (clearDpe) begin
      dpe_d = 1'b0;
    end
    if (evt.dataParityErr || evt.addrParityErr) begin
      dpe_d = 1'b1;
    end
    perrN_d = !(evt.dataParityErr && cmd_q[BIT_PARITY]);
    serrN_d = !(evt.addrParityErr && cmd_q[BIT_SERR]
                && cmd_q[BIT_PARITY]);
    io_d = evt.ioSpaceHit && cmd_q[BIT_IO];
    snp_d = evt.paletteWrite && cmd_q[BIT_SNOOP];
    mem_d = evt.memSpaceHit && cmd_q[BIT_MEM]
            && !(evt.paletteWrite && cmd_q[BIT_SNOOP]);
    sc_d = evt.specialCycle && cmd_q[BIT_SPECIAL];
    bm_d = evt.masterReq && cmd_q[BIT_MASTER];
    mwi_d = evt.masterWantsMwi && cmd_q[BIT_MASTER]
            && cmd_q[BIT_MWI];
    par_d = ^{txData, txByteEnN};
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      cmd_q <= CMD_RESET;
      rd_q <= 16'h0000;
      rv_q <= 1'b0;
      dpe_q <= 1'b0;
      perrN_q <= 1'b1;
      serrN_q <= 1'b1;
      mem_q <= 1'b0;
      io_q <= 1'b0;
      snp_q <= 1'b0;
      sc_q <= 1'b0;
      bm_q <= 1'b0;
      mwi_q <= 1'b0;
      par_q <= 1'b0;
    end else if (clkEn) begin
      cmd_q <= cmd_d;
      rd_q <= rd_d;
      rv_q <= rv_d;
      dpe_q <= dpe_d;
      perrN_q <= perrN_d;
      serrN_q <= serrN_d;
      mem_q <= mem_d;
      io_q <= io_d;
      snp_q <= snp_d;
      sc_q <= sc_d;
      bm_q <= bm_d;
      mwi_q <= mwi_d;
      par_q <= par_d;
    end
  end

  assign cfgRdata = rd_q;
  assign cfgRvalid = rv_q;
  assign memClaim = mem_q;
  assign ioClaim = io_q;
  assign paletteSnoop = snp_q;
  assign specialAccept = sc_q;
  assign masterGrantOk = bm_q;
  assign useMwi = mwi_q;
  assign parityOut = par_q;
  assign parityErrN = perrN_q;
  assign systemErrN = serrN_q;
  assign detectedParityErr = dpe_q;

  property p_io_gate;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.ioSpaceHit && !cmd_q[BIT_IO] |=> !ioClaim;
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("io claimed");
  property p_mem_gate;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.memSpaceHit && !cmd_q[BIT_MEM] |=> !memClaim;
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("mem claimed");
  property p_snoop;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.paletteWrite && cmd_q[BIT_SNOOP]
      |=> !memClaim && paletteSnoop;
  endproperty
  a_snoop: assert property (p_snoop) else $error("palette claimed");
  property p_special;
    @(posedge clk) disable iff (!rstSync)
    clkEn && !cmd_q[BIT_SPECIAL] |=> !specialAccept;
  endproperty
  a_special: assert property (p_special) else $error("special seen");
  property p_master;
    @(posedge clk) disable iff (!rstSync)
    clkEn && !cmd_q[BIT_MASTER] |=> !masterGrantOk && !useMwi;
  endproperty
  a_master: assert property (p_master) else $error("master active");
  property p_mwi;
    @(posedge clk) disable iff (!rstSync)
    clkEn && !cmd_q[BIT_MWI] |=> !useMwi;
  endproperty
  a_mwi: assert property (p_mwi) else $error("mwi used");
  property p_perr_off;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.dataParityErr && !cmd_q[BIT_PARITY]
      |=> parityErrN && detectedParityErr;
  endproperty
  a_perr_off: assert property (p_perr_off) else $error("perr wrong");
  property p_perr_on;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.dataParityErr && cmd_q[BIT_PARITY] |=> !parityErrN;
  endproperty
  a_perr_on: assert property (p_perr_on) else $error("perr missing");
  property p_serr;
    @(posedge clk) disable iff (!rstSync)
    !systemErrN |-> $past(cmd_q[BIT_SERR]) && $past(cmd_q[BIT_PARITY]);
  endproperty
  a_serr: assert property (p_serr) else $error("serr ungated");
  property p_fixed;
    @(posedge clk) disable iff (!rstSync)
    cfgRvalid |-> cfgRdata[BIT_STEP] == 1'b0 && cfgRdata[BIT_SNOOP] == 1'b0;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bit moved");
  sequence s_cmd_write;
    clkEn && hit && cfgReq.write && cfgReq.byteEn == 2'b11;
  endsequence
  sequence s_zero_write;
    clkEn && hit && cfgReq.write && cfgReq.byteEn == 2'b11
      && cfgReq.data == 16'h0000;
  endsequence
  sequence s_cmd_read;
    clkEn && hit && !cfgReq.write;
  endsequence
  sequence s_bus_quiet;
    !memClaim && !ioClaim && !masterGrantOk && !useMwi && !specialAccept;
  endsequence
  property p_write_lands;
    @(posedge clk) disable iff (!rstSync)
    s_cmd_write |=> cmd_q == ($past(cfgReq.data) & CMD_WMASK);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("no write");
  property p_disconnect;
    @(posedge clk) disable iff (!rstSync)
    s_zero_write ##1 clkEn |=> s_bus_quiet;
  endproperty
  a_disconnect: assert property (p_disconnect) else $error("not off");
  property p_read_answer;
    @(posedge clk) disable iff (!rstSync)
    s_cmd_read |=> cfgRvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no read");
  property p_read_data;
    @(posedge clk) disable iff (!rstSync)
    s_cmd_read |=> cfgRdata == $past(cmd_q);
  endproperty
  a_read_data: assert property (p_read_data) else $error("bad read");
  property p_other_offset;
    @(posedge clk) disable iff (!rstSync)
    clkEn && cfgReq.valid && cfgReq.offset != CMD_OFFSET |=> !cfgRvalid;
  endproperty
  a_other_offset: assert property (p_other_offset) else $error("answered");
  property p_idle_data;
    @(posedge clk) disable iff (!rstSync)
    !cfgRvalid |-> cfgRdata == 16'h0000;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("data leak");
  property p_step_fixed;
    @(posedge clk) disable iff (!rstSync)
    cmd_q[BIT_STEP] == 1'b0;
  endproperty
  a_step_fixed: assert property (p_step_fixed) else $error("stepping");
  property p_fixed_q;
    @(posedge clk) disable iff (!rstSync)
    (cmd_q & ~CMD_WMASK) == 16'h0000;
  endproperty
  a_fixed_q: assert property (p_fixed_q) else $error("fixed bits set");
  property p_freeze;
    @(posedge clk) disable iff (!rstSync)
    !clkEn |=> $stable(cmd_q) && $stable(detectedParityErr);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved");
  property p_dpe_set;
    @(posedge clk) disable iff (!rstSync)
    clkEn && (evt.dataParityErr || evt.addrParityErr) |=> detectedParityErr;
  endproperty
  a_dpe_set: assert property (p_dpe_set) else $error("flag not set");
  property p_dpe_clear;
    @(posedge clk) disable iff (!rstSync)
    clkEn && clearDpe && !evt.dataParityErr && !evt.addrParityErr
      |=> !detectedParityErr;
  endproperty
  a_dpe_clear: assert property (p_dpe_clear) else $error("flag stuck");
  property p_dpe_hold;
    @(posedge clk) disable iff (!rstSync)
    clkEn && !clearDpe && detectedParityErr |=> detectedParityErr;
  endproperty
  a_dpe_hold: assert property (p_dpe_hold) else $error("flag lost");
  property p_parity;
    @(posedge clk) disable iff (!rstSync)
    clkEn && rstSync |=> parityOut == $past(^{txData, txByteEnN});
  endproperty
  a_parity: assert property (p_parity) else $error("bad parity");
  property p_serr_on;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.addrParityErr && cmd_q[BIT_SERR] && cmd_q[BIT_PARITY]
      |=> !systemErrN;
  endproperty
  a_serr_on: assert property (p_serr_on) else $error("serr missing");
  property p_serr_par;
    @(posedge clk) disable iff (!rstSync)
    clkEn && !cmd_q[BIT_PARITY] |=> systemErrN && parityErrN;
  endproperty
  a_serr_par: assert property (p_serr_par) else $error("pin driven");
  property p_io_on;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.ioSpaceHit && cmd_q[BIT_IO] |=> ioClaim;
  endproperty
  a_io_on: assert property (p_io_on) else $error("io not claimed");
  property p_mem_on;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.memSpaceHit && cmd_q[BIT_MEM]
      && !(evt.paletteWrite && cmd_q[BIT_SNOOP]) |=> memClaim;
  endproperty
  a_mem_on: assert property (p_mem_on) else $error("mem not claimed");
  property p_bm_on;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.masterReq && cmd_q[BIT_MASTER] |=> masterGrantOk;
  endproperty
  a_bm_on: assert property (p_bm_on) else $error("master blocked");
  property p_mwi_on;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.masterWantsMwi && cmd_q[BIT_MASTER] && cmd_q[BIT_MWI]
      |=> useMwi;
  endproperty
  a_mwi_on: assert property (p_mwi_on) else $error("mwi blocked");
  property p_sc_on;
    @(posedge clk) disable iff (!rstSync)
    clkEn && evt.specialCycle && cmd_q[BIT_SPECIAL] |=> specialAccept;
  endproperty
  a_sc_on: assert property (p_sc_on) else $error("special missed");
  property p_perr_idle;
    @(posedge clk) disable iff (!rstSync)
    clkEn && !evt.dataParityErr |=> parityErrN;
  endproperty
  a_perr_idle: assert property (p_perr_idle) else $error("perr stray");
endmodule
`default_nettype wire

/* File: tb/pcc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pcc_host_model
  import pcc_pkg::*;
(
  output var pcc_cfg_s cfgReq
  , input wire logic clk
);
  initial cfgReq = '0;
  // One-cycle config cycle; fields scrambled once released
  task automatic access(input logic wr, input logic [7:0] off,
                        input logic [15:0] d);
    @(posedge clk);
    cfgReq <= '{1'b1, wr, off, 2'b11, d};
    @(posedge clk);
    cfgReq <= '{1'b0, ~wr, ~off, 2'b00, ~d};
  endtask
endmodule
`default_nettype wire

/* File: tb/test_pci_command_low_controls.sv */
`timescale 1ns/100ps
`default_nettype none
module test_pci_command_low_controls;
  import pcc_pkg::*;
  logic clk, rst_n, clkEn, clearDpe;
  pcc_cfg_s cfgReq;
  pcc_evt_s evt;
  logic [31:0] txData;
  logic [3:0] txByteEnN;
  logic [15:0] cfgRdata;
  logic cfgRvalid, memClaim, ioClaim, paletteSnoop, specialAccept;
  logic masterGrantOk, useMwi, parityOut, parityErrN, systemErrN;
  logic detectedParityErr;
  int n_fail = 0;
  int total_checks = 0;
  // Written value, expected read-back
  logic [31:0] rows [10] = '{32'hffff0357, 32'h00000000, 32'h00010001,
    32'h00020002, 32'h00040004, 32'h00100010, 32'h00400040,
    32'h01000100, 32'h02000200, 32'h00a80000};
  pcc_host_model pcc_host_model_i (.clk(clk), .cfgReq(cfgReq));
  pcc_command_low pcc_command_low_i (.clk(clk), .rst_n(rst_n),
    .clkEn(clkEn), .cfgReq(cfgReq), .txData(txData),
    .txByteEnN(txByteEnN), .clearDpe(clearDpe), .evt(evt),
    .cfgRdata(cfgRdata), .cfgRvalid(cfgRvalid), .memClaim(memClaim),
    .ioClaim(ioClaim), .paletteSnoop(paletteSnoop),
    .specialAccept(specialAccept), .masterGrantOk(masterGrantOk),
    .useMwi(useMwi), .parityOut(parityOut), .parityErrN(parityErrN),
    .systemErrN(systemErrN), .detectedParityErr(detectedParityErr));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    pcc_host_model_i.access(1'b1, CMD_OFFSET, d);
  endtask
  task automatic rd(input logic [7:0] off, input logic [15:0] e,
                    input logic v);
    pcc_host_model_i.access(1'b0, off, 16'h0000);
    #1 chk({15'h0, cfgRvalid}, {15'h0, v});
    if (v) chk(cfgRdata, e);
  endtask
  // Pulse events, check claims and error pins one cycle later
  task automatic fire(input pcc_evt_s e, input logic [7:0] x);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    #1 chk({8'h0, memClaim, ioClaim, paletteSnoop, specialAccept,
            masterGrantOk, useMwi, parityErrN, systemErrN}, {8'h0, x});
  endtask
  task automatic clr();
    @(posedge clk);
    clearDpe <= 1'b1;
    @(posedge clk);
    clearDpe <= 1'b0;
    @(posedge clk);
    #1 chk({15'h0, detectedParityErr}, 16'h0000);
  endtask
  initial begin
    #20000 n_fail++;
    summarize();
  end
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    clearDpe = 1'b0;
    evt = '0;
    txData = 32'h0;
    txByteEnN = 4'h0;
    repeat (10) @(posedge clk);
    chk({13'h0, parityErrN, systemErrN, detectedParityErr}, 16'h0006);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(CMD_OFFSET, CMD_RESET, 1'b1);
    fire(8'hfc, 8'h03);
    foreach (rows[i]) begin
      wr(rows[i][31:16]);
      rd(CMD_OFFSET, rows[i][15:0], 1'b1);
    end
    rd(8'h08, 16'h0000, 1'b0);
    clkEn <= 1'b0;
    wr(16'h0001);
    clkEn <= 1'b1;
    rd(CMD_OFFSET, 16'h0000, 1'b1);
    wr(16'h0004);
    fire(8'hfc, 8'h0b);
    wr(16'h0357);
    fire(8'hfc, 8'hcf);
    txData <= 32'h0000_0001;
    fire(8'h00, 8'h03);
    chk({15'h0, parityOut}, 16'h0001);
    wr(16'h0000);
    fire(8'h02, 8'h03);
    chk({15'h0, detectedParityErr}, 16'h0001);
    clr();
    wr(16'h0040);
    fire(8'h02, 8'h01);
    fire(8'h01, 8'h03);
    clr();
    wr(16'h0140);
    fire(8'h01, 8'h02);
    summarize();
  end
endmodule
`default_nettype wire
